/* core/acs_sequencer.sv */
// conversion sequencer: start control, phases, flags and result transfer
//
// Summary of operation
// RL1: register write starts conversion when internal start
// RL2: software trigger restarts a running conversion
// RL3: conversion and busy begin next cycle
// RL4: external start: low pin starts, writes don't
// RL5: capacitor array connected throughout sample phase
// RL6: load, then rest of sample, then approximation
// RL7: last cycle moves value into result register
// RL8: busy clears before the result transfer cycle
// RL9: completion sets done flag in request register
// RL10: done flag set fixed cycles before transfer
// RL11: continuous: next conversion starts right after
// RL12: single mode one conversion; continuous repeats
// RL13: external continuous runs while pin stays low
// RL14: result held until overwritten; software accessible
// RL15: phase lengths and flag lead are parameters
// RL16: software clears done flag after servicing
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int LOAD_CYC = ACS_LOAD_CYC,
  parameter int SAMPLE_CYC = ACS_SAMPLE_CYC,
  parameter int TOTAL_CYC = ACS_TOTAL_CYC,
  parameter int DONE_LEAD_CYC = ACS_DONE_LEAD_CYC,
  parameter int BUSY_LEAD_CYC = ACS_BUSY_LEAD_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ACS_ADDR_W-1:0] bus_addr,
  input wire logic [ACS_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [ACS_DATA_W-1:0] bus_rdata,
  input wire logic external_start_pin_n,
  input wire logic comparator_above,
  output acs_analog_type analog_ctrl,
  output logic conversion_busy_flag,
  output logic conversion_done_flag
);

  localparam int CNT_W = ACS_CNT_W;
  // phase boundaries as counter values
  localparam logic [CNT_W-1:0] LOAD_C = CNT_W'(LOAD_CYC); // [RL15]
  localparam logic [CNT_W-1:0] SAMPLE_C = CNT_W'(SAMPLE_CYC); // [RL15]
  localparam logic [CNT_W-1:0] SAR_END_C = CNT_W'(SAMPLE_CYC + ACS_SAR_BITS);
  localparam logic [CNT_W-1:0] LAST_C = CNT_W'(TOTAL_CYC - 1); // [RL15]
  localparam logic [CNT_W-1:0] DONE_C = CNT_W'(TOTAL_CYC - 1 - DONE_LEAD_CYC); // [RL15]
  localparam logic [CNT_W-1:0] BUSY_END_C = CNT_W'(TOTAL_CYC - BUSY_LEAD_CYC);

  typedef struct packed {
    acs_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [ACS_CTRL_CHAN_W-1:0] chan;
    logic cont;
    logic ext;
    logic [ACS_DATA_W-1:0] ref_prog;
    logic [ACS_DATA_W-1:0] result;
    logic [ACS_DATA_W-1:0] irq;
    logic [ACS_DATA_W-1:0] rdata;
    logic pin_meta;
    logic pin_sync;
    logic pin_last;
  } acs_main_state_type;

  acs_main_state_type s_r;
  acs_main_state_type s_nxt;

  logic running;
  logic last_cyc;
  logic int_start;
  logic ext_fall;
  logic ext_hold;
  logic auto_next;
  logic start;
  logic done_set;
  logic sar_step;
  logic [ACS_SAR_BITS-1:0] sar_code;

  // assemble the control/status byte
  function automatic logic [ACS_DATA_W-1:0] ctrl_byte(input acs_main_state_type s,
                                                     input logic busy);
    logic [ACS_DATA_W-1:0] v;
    v = ACS_CTRL_RESET;
    v[ACS_CTRL_CHAN_LSB +: ACS_CTRL_CHAN_W] = s.chan;
    v[ACS_CTRL_CONT_BIT] = s.cont;
    v[ACS_CTRL_BUSY_BIT] = busy;
    v[ACS_CTRL_EXT_BIT] = s.ext;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // start and phase decode
  // ---------------------------------------------------------------
  assign running = (s_r.state == ACS_RUN);
  assign last_cyc = running && (s_r.cnt == LAST_C);
  // any written value starts, only with internal start selected
  assign int_start = bus_wr && (bus_addr == ACS_REF_ADDR) && !s_r.ext; // [RL1] [RL4]
  // high in one sample, low in the next
  assign ext_fall = s_r.ext && s_r.pin_last && !s_r.pin_sync; // [RL4]
  // continuous external: idle while pin is low starts again
  assign ext_hold = s_r.ext && s_r.cont && !running && !s_r.pin_sync; // [RL13]
  // continuous: chain directly after the last cycle
  assign auto_next = last_cyc && s_r.cont && (!s_r.ext || !s_r.pin_sync); // [RL11] [RL12] [RL13]
  assign start = int_start || ext_fall || ext_hold || auto_next; // [RL2]
  assign done_set = running && (s_r.cnt == DONE_C); // [RL9] [RL10]
  assign sar_step = running && (s_r.cnt >= SAMPLE_C) && (s_r.cnt < SAR_END_C); // [RL6]

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // two-flop synchroniser plus one history flop
    s_nxt.pin_meta = external_start_pin_n;
    s_nxt.pin_sync = s_r.pin_meta;
    s_nxt.pin_last = s_r.pin_sync;

    // software writes
    if (bus_wr) begin
      case (bus_addr)
        ACS_CTRL_ADDR: begin
          s_nxt.chan = bus_wdata[ACS_CTRL_CHAN_LSB +: ACS_CTRL_CHAN_W];
          s_nxt.cont = bus_wdata[ACS_CTRL_CONT_BIT];
          s_nxt.ext = bus_wdata[ACS_CTRL_EXT_BIT];
        end
        ACS_RESULT_ADDR: s_nxt.result = bus_wdata; // [RL14]
        ACS_REF_ADDR: s_nxt.ref_prog = bus_wdata;
        ACS_IRQ_ADDR: s_nxt.irq = bus_wdata; // [RL16]
        default: ;
      endcase
    end

    // conversion sequence
    unique case (s_r.state)
      ACS_IDLE: ;
      ACS_RUN: begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        if (last_cyc) begin
          s_nxt.result = sar_code; // [RL7]
          s_nxt.state = ACS_IDLE; // [RL12]
        end
      end
    endcase

    // hardware set wins over a software clear
    if (done_set) begin
      s_nxt.irq[ACS_IRQ_DONE_BIT] = 1'b1; // [RL9]
    end

    // a trigger abandons any running conversion
    if (start) begin
      s_nxt.state = ACS_RUN; // [RL3]
      s_nxt.cnt = '0; // [RL2]
    end

    // read data valid only in the cycle after the strobe
    s_nxt.rdata = '0;
    if (bus_rd) begin
      case (bus_addr)
        ACS_CTRL_ADDR: s_nxt.rdata = ctrl_byte(s_r, conversion_busy_flag);
        ACS_RESULT_ADDR: s_nxt.rdata = s_r.result; // [RL14]
        ACS_REF_ADDR: s_nxt.rdata = s_r.ref_prog;
        ACS_IRQ_ADDR: s_nxt.rdata = s_r.irq;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r.state <= ACS_IDLE;
      s_r.cnt <= '0;
      s_r.chan <= ACS_CTRL_RESET[ACS_CTRL_CHAN_LSB +: ACS_CTRL_CHAN_W];
      s_r.cont <= ACS_CTRL_RESET[ACS_CTRL_CONT_BIT];
      s_r.ext <= ACS_CTRL_RESET[ACS_CTRL_EXT_BIT];
      s_r.ref_prog <= ACS_REF_RESET;
      s_r.result <= ACS_RESULT_RESET;
      s_r.irq <= ACS_IRQ_RESET;
      s_r.rdata <= '0;
      s_r.pin_meta <= 1'b1;
      s_r.pin_sync <= 1'b1;
      s_r.pin_last <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // approximation engine
  // ---------------------------------------------------------------
  acs_sar #(
    .BITS(ACS_SAR_BITS)
  ) u_sar (
    .clk(clk),
    .reset(reset),
    .clear(start),
    .step(sar_step),
    .comp_above(comparator_above),
    .code(sar_code)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // busy drops before the transfer cycle
  assign conversion_busy_flag = running && (s_r.cnt < BUSY_END_C); // [RL3] [RL8]
  assign conversion_done_flag = s_r.irq[ACS_IRQ_DONE_BIT];
  assign bus_rdata = s_r.rdata;
  assign analog_ctrl.sample_connect = running && (s_r.cnt < SAMPLE_C); // [RL5]
  assign analog_ctrl.load_phase = running && (s_r.cnt < LOAD_C); // [RL6]
  assign analog_ctrl.channel = s_r.chan;
  assign analog_ctrl.ref_program = s_r.ref_prog;
  assign analog_ctrl.trial_code = sar_code;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_write_starts: assert property (int_start |=> running && s_r.cnt == '0 && conversion_busy_flag) // [RL1]
    else $error("reference write did not start a conversion");

  a_restart_running: assert property (running && s_r.cnt > '0 && int_start |=> s_r.cnt == '0) // [RL2]
    else $error("running conversion not restarted");

  a_busy_next: assert property (!running && start |-> !conversion_busy_flag ##1 conversion_busy_flag) // [RL3]
    else $error("busy not set in the following cycle");

  a_ext_pin_start: assert property (s_r.ext && $fell(s_r.pin_sync) |=> running && s_r.cnt == '0) // [RL4]
    else $error("low pin level did not start conversion");

  a_ext_ignores_write: assert property (s_r.ext && !running && s_r.pin_sync && !s_r.cont // [RL4]
                                        && bus_wr && bus_addr == ACS_REF_ADDR |=> !running)
    else $error("write started conversion under external start");

  a_sample_connect: assert property (running && s_r.cnt == '0 && !start // [RL5]
                                     |-> analog_ctrl.sample_connect [*5])
    else $error("capacitor array left input during sample phase");

  a_phase_order: assert property (analog_ctrl.load_phase |-> analog_ctrl.sample_connect && !sar_step) // [RL6]
    else $error("load phase outside sample phase");

  a_result_moves: assert property (last_cyc |=> s_r.result == $past(sar_code)) // [RL7]
    else $error("result not transferred in last cycle");

  a_busy_before: assert property (last_cyc |-> !conversion_busy_flag && $past(running)) // [RL8]
    else $error("busy still set in transfer cycle");

  a_done_lead: assert property (done_set && !start ##1 !start ##1 !start |=> last_cyc) // [RL10]
    else $error("done flag lead wrong");

  a_done_sets: assert property (done_set |=> conversion_done_flag) // [RL9]
    else $error("completion did not set done flag");

  a_cont_next: assert property (last_cyc && s_r.cont && !s_r.ext |=> running && s_r.cnt == '0) // [RL11]
    else $error("continuous mode did not chain");

  a_single_stops: assert property (last_cyc && !s_r.cont && !start |=> !running) // [RL12]
    else $error("single mode did not stop");

  a_ext_cont_stop: assert property (last_cyc && s_r.ext && s_r.cont && s_r.pin_sync // [RL13]
                                    && !ext_fall && !int_start |=> !running)
    else $error("external continuous ran on with pin high");

  a_result_holds: assert property (!last_cyc // [RL14]
                                   && !(bus_wr && bus_addr == ACS_RESULT_ADDR)
                                   |=> $stable(s_r.result))
    else $error("result changed without cause");

  a_done_keeps: assert property (conversion_done_flag // [RL9]
                                 && !(bus_wr && bus_addr == ACS_IRQ_ADDR)
                                 |=> conversion_done_flag)
    else $error("done flag dropped without a software write");

  a_result_read: assert property (bus_rd && bus_addr == ACS_RESULT_ADDR // [RL14]
                                  |=> bus_rdata == $past(s_r.result))
    else $error("result register read back wrong");

  a_rdata_quiet: assert property (!bus_rd |=> bus_rdata == '0) // [RL14]
    else $error("read data present without a read strobe");

  a_channel_follows: assert property (bus_wr && bus_addr == ACS_CTRL_ADDR // [RL5]
                                      |=> analog_ctrl.channel
                                      == $past(bus_wdata[ACS_CTRL_CHAN_LSB +: ACS_CTRL_CHAN_W]))
    else $error("selected channel not taken from control write");

  a_ext_hold_start: assert property (s_r.ext && s_r.cont && !running && !s_r.pin_sync // [RL13]
                                     |=> running && s_r.cnt == '0)
    else $error("low pin did not start continuous external conversion");

  a_sar_after_sample: assert property (sar_step // [RL6]
                                       |-> running && !analog_ctrl.sample_connect)
    else $error("approximation overlaps sample phase");

  // main scenarios reached
  c_single_done: cover property (running && !s_r.cont ##1 last_cyc ##1 !running);
  c_continuous: cover property (last_cyc && s_r.cont ##1 running ##[1:20] last_cyc);
  c_restart: cover property (running && s_r.cnt > SAMPLE_C && int_start);
  c_ext_start: cover property (ext_fall ##1 running);
  c_ext_hold: cover property (ext_hold ##1 running);

endmodule

/* inc/acs_pkg.sv */
// shared constants and types of the conversion sequencer
package acs_pkg;

  // ---------------------------------------------------------------
  // register bus geometry
  // ---------------------------------------------------------------
  localparam int ACS_ADDR_W = 8;
  localparam int ACS_DATA_W = 8;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ACS_IRQ_ADDR = 8'hc0;    // interrupt_request_flags
  localparam logic [7:0] ACS_CTRL_ADDR = 8'hd8;   // converter control and status
  localparam logic [7:0] ACS_RESULT_ADDR = 8'hd9; // conversion_result_register
  localparam logic [7:0] ACS_REF_ADDR = 8'hda;    // reference_program_register

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ACS_CTRL_CHAN_LSB = 0;
  localparam int ACS_CTRL_CHAN_W = 3;
  localparam int ACS_CTRL_CONT_BIT = 3;
  localparam int ACS_CTRL_BUSY_BIT = 4;
  localparam int ACS_CTRL_EXT_BIT = 5;
  localparam int ACS_IRQ_DONE_BIT = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACS_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACS_IRQ_RESET = 8'h00;
  localparam logic [7:0] ACS_RESULT_RESET = 8'h00;
  localparam logic [7:0] ACS_REF_RESET = 8'h00;

  // ---------------------------------------------------------------
  // timing in machine cycles (one clk period each), clock period in ns, code and counter widths
  // ---------------------------------------------------------------
  localparam int ACS_CLK_PERIOD_NS = 50;
  localparam int ACS_LOAD_CYC = 2;
  localparam int ACS_SAMPLE_CYC = 5;
  localparam int ACS_TOTAL_CYC = 14;
  localparam int ACS_DONE_LEAD_CYC = 3;
  localparam int ACS_BUSY_LEAD_CYC = 1;
  localparam int ACS_SAR_BITS = 8;
  localparam int ACS_CNT_W = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {ACS_IDLE, ACS_RUN} acs_state_type;

  // controls toward the analog converter core
  typedef struct packed {
    logic sample_connect;
    logic load_phase;
    logic [ACS_CTRL_CHAN_W-1:0] channel;
    logic [ACS_DATA_W-1:0] ref_program;
    logic [ACS_SAR_BITS-1:0] trial_code;
  } acs_analog_type;

endpackage

/* core/acs_sar.sv */
// successive-approximation code register of the conversion sequencer
`timescale 1ns/1ps
module acs_sar
  import acs_pkg::*;
#(
  parameter int BITS = ACS_SAR_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic step,
  input wire logic comp_above,
  output logic [BITS-1:0] code
);

  typedef struct packed {
    logic [BITS-1:0] trial;
    logic [BITS-1:0] mask;
  } acs_sar_state_type;

  acs_sar_state_type s_r;
  acs_sar_state_type s_nxt;

  // ---------------------------------------------------------------
  // bit decisions, most significant first
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.trial = {1'b1, {(BITS-1){1'b0}}};
      s_nxt.mask = {1'b1, {(BITS-1){1'b0}}};
    end else if (step && (s_r.mask != '0)) begin
      // keep the tried bit only if input lies above the trial level
      s_nxt.trial = (comp_above ? s_r.trial : (s_r.trial & ~s_r.mask)) | (s_r.mask >> 1);
      s_nxt.mask = s_r.mask >> 1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign code = s_r.trial;

endmodule

/* verification/acs_source_model.sv */
// analog source model answering the sequencer's comparator
`timescale 1ns/1ps
module acs_source_model
  import acs_pkg::*;
(
  input wire acs_analog_type analog_ctrl,
  input wire logic [7:0] level,
  output logic comparator_above
);
  // ---------------------------------------------------------------
  // comparator
  // ---------------------------------------------------------------
  // source sits half a step above its code, so no trial level ever ties
  assign comparator_above = {level, 1'b1} > {analog_ctrl.trial_code, 1'b0};
endmodule

/* verification/adc_conversion_sequencer_bench.sv */
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_bench
  import acs_pkg::*;
;
  typedef struct packed {
    logic [2:0] chan;
    logic [7:0] refv;
    logic [7:0] lvl;
  } acs_row_type;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic external_start_pin_n = 1'b1;
  logic comparator_above;
  acs_analog_type analog_ctrl;
  logic conversion_busy_flag;
  logic conversion_done_flag;
  logic [7:0] level = 8'h00;
  int errors = 0;
  int n_checks = 0;
  int k;
  acs_row_type rows [3] = '{'{3'h0, 8'h00, 8'h00}, '{3'h5, 8'h4c, 8'hff},
                            '{3'h7, 8'hf3, 8'h5a}};

  // ---------------------------------------------------------------
  // clock, design and source
  // ---------------------------------------------------------------
  // 20 MHz machine-cycle clock
  always #25 clk = ~clk;

  acs_sequencer u_dut (
    .clk(clk),
    .reset(reset),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .external_start_pin_n(external_start_pin_n),
    .comparator_above(comparator_above),
    .analog_ctrl(analog_ctrl),
    .conversion_busy_flag(conversion_busy_flag),
    .conversion_done_flag(conversion_done_flag)
  );

  acs_source_model u_src (
    .analog_ctrl(analog_ctrl),
    .level(level),
    .comparator_above(comparator_above)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // verdict and end of run
  task conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk_b(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task chk_f(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // read strobe, data compared in the following cycle
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk_b(bus_rdata, exp, "read data");
  endtask

  // follows one conversion cycle by cycle from cycle 0
  task run_conv(input logic d0);
    for (int i = 0; i < ACS_TOTAL_CYC; i++) begin
      #1;
      chk_f(conversion_busy_flag, i < ACS_TOTAL_CYC - ACS_BUSY_LEAD_CYC, "busy");
      chk_f(conversion_done_flag, d0 || i >= ACS_TOTAL_CYC - ACS_DONE_LEAD_CYC, "done");
      chk_f(analog_ctrl.sample_connect, i < ACS_SAMPLE_CYC, "sample");
      chk_f(analog_ctrl.load_phase, i < ACS_LOAD_CYC, "load");
      @(posedge clk);
    end
  endtask

  // bounded wait for the busy flag to reach a level
  task wait_busy(input logic lvl);
    // step off the edge so the flag is read settled
    #1;
    for (k = 0; k < 40 && conversion_busy_flag !== lvl; k++) begin
      @(posedge clk);
      #1;
    end
    if (conversion_busy_flag !== lvl) begin
      errors++;
      conclude();
    end
  endtask

  // checks the flag stays low for a stretch of cycles
  task idle_check;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      #1 chk_f(conversion_busy_flag, 1'b0, "no start");
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(ACS_IRQ_ADDR, ACS_IRQ_RESET);
    rd(ACS_CTRL_ADDR, ACS_CTRL_RESET);
    rd(ACS_RESULT_ADDR, ACS_RESULT_RESET);
    rd(ACS_REF_ADDR, ACS_REF_RESET);
    rd(8'h55, 8'h00);
    wr(ACS_CTRL_ADDR, 8'h10);
    rd(ACS_CTRL_ADDR, 8'h00);
    // single internal conversions from the table
    foreach (rows[r]) begin
      level <= rows[r].lvl;
      wr(ACS_CTRL_ADDR, {5'h00, rows[r].chan});
      wr(ACS_RESULT_ADDR, ~rows[r].lvl);
      rd(ACS_RESULT_ADDR, ~rows[r].lvl);
      wr(ACS_REF_ADDR, rows[r].refv);
      run_conv(1'b0);
      #1 chk_f(conversion_busy_flag, 1'b0, "single");
      chk_b(analog_ctrl.ref_program, rows[r].refv, "ref");
      chk_b({5'h00, analog_ctrl.channel}, {5'h00, rows[r].chan}, "chan");
      rd(ACS_RESULT_ADDR, rows[r].lvl);
      rd(ACS_IRQ_ADDR, 8'h01);
      wr(ACS_IRQ_ADDR, 8'h00);
      rd(ACS_IRQ_ADDR, 8'h00);
    end
    // restart of a running conversion
    level <= 8'h33;
    wr(ACS_REF_ADDR, 8'h80);
    repeat (6) @(posedge clk);
    wr(ACS_REF_ADDR, 8'h80);
    run_conv(1'b0);
    rd(ACS_RESULT_ADDR, 8'h33);
    wr(ACS_IRQ_ADDR, 8'h00);
    // continuous internal: chained, then stopped by software
    level <= 8'hc6;
    wr(ACS_CTRL_ADDR, 8'h0a);
    wr(ACS_REF_ADDR, 8'h80);
    run_conv(1'b0);
    run_conv(1'b1);
    wr(ACS_CTRL_ADDR, 8'h02);
    wait_busy(1'b0);
    idle_check();
    rd(ACS_RESULT_ADDR, 8'hc6);
    wr(ACS_IRQ_ADDR, 8'h00);
    // external single: writes ignored, low pin starts one
    level <= 8'h3c;
    wr(ACS_CTRL_ADDR, 8'h20);
    wr(ACS_REF_ADDR, 8'h11);
    idle_check();
    @(posedge clk);
    external_start_pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    run_conv(1'b0);
    rd(ACS_RESULT_ADDR, 8'h3c);
    idle_check();
    @(posedge clk);
    external_start_pin_n <= 1'b1;
    wr(ACS_IRQ_ADDR, 8'h00);
    // external continuous: runs while the pin stays low
    wr(ACS_CTRL_ADDR, 8'h28);
    level <= 8'h9b;
    @(posedge clk);
    external_start_pin_n <= 1'b0;
    wait_busy(1'b1);
    run_conv(1'b0);
    run_conv(1'b1);
    external_start_pin_n <= 1'b1;
    wait_busy(1'b0);
    idle_check();
    rd(ACS_RESULT_ADDR, 8'h9b);
    // reset in mid-conversion returns control, request and result registers to their reset values
    wr(ACS_CTRL_ADDR, 8'h00);
    wr(ACS_REF_ADDR, 8'h80);
    repeat (3) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 chk_f(conversion_busy_flag, 1'b0, "reset busy");
    chk_f(conversion_done_flag, 1'b0, "reset done");
    chk_f(analog_ctrl.sample_connect, 1'b0, "reset sample");
    rd(ACS_CTRL_ADDR, ACS_CTRL_RESET);
    rd(ACS_IRQ_ADDR, ACS_IRQ_RESET);
    rd(ACS_RESULT_ADDR, ACS_RESULT_RESET);
    idle_check();
    conclude();
  end
endmodule
